// >>> src/vat_pkg.sv
package vat_pkg;
  // ***********************************************************
  // Widths and sizes
  // ***********************************************************
  localparam int VADDR_W = 32;
  localparam int PADDR_W = 29;
  localparam int SPACE_IDENTIFIER_W = 8;
  localparam int VPN_W = 22;
  localparam int PPN_W = 19;
  localparam int INSTRUCTION_XLAT_BUFFER_N = 4;
  localparam int UNIFIED_XLAT_BUFFER_N = 64;
  localparam int UIDX_W = 6;
  localparam int CNT_W = 6;

  // ***********************************************************
  // Register map, control area and area 7 alias
  // ***********************************************************
  localparam logic [31:0] REG_PAGE_ENTRY_HIGH = 32'hff00_0000;
  localparam logic [31:0] REG_PAGE_ENTRY_LOW = 32'hff00_0004;
  localparam logic [31:0] REG_TABLE_BASE = 32'hff00_0008;
  localparam logic [31:0] REG_FAULT_ADDRESS = 32'hff00_000c;
  localparam logic [31:0] REG_TRANSLATOR_CONTROL = 32'hff00_0010;
  localparam logic [31:0] REG_PAGE_ENTRY_ASSIST = 32'hff00_0034;
  localparam logic [7:0] CTRL_AREA_TOP = 8'hff;
  localparam logic [4:0] AREA7_TOP = 5'h1f;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ***********************************************************
  // Control register fields
  // ***********************************************************
  localparam int CTRL_AT_BIT = 0;
  localparam int CTRL_TI_BIT = 2;
  localparam int CTRL_SV_BIT = 8;
  localparam int CTRL_URC_LSB = 10;
  localparam int CTRL_URB_LSB = 18;

  // ***********************************************************
  // Page entry fields
  // ***********************************************************
  localparam int PEH_VPN_LSB = 10;
  localparam int PEL_PPN_LSB = 10;
  localparam int PEL_V_BIT = 8;
  localparam int PEL_SZ1_BIT = 7;
  localparam int PEL_PR_LSB = 5;
  localparam int PEL_SZ0_BIT = 4;
  localparam int PEL_SH_BIT = 1;

  // ***********************************************************
  // Page sizes and access rights
  // ***********************************************************
  localparam logic [1:0] SZ_1K = 2'h0;
  localparam logic [1:0] SZ_4K = 2'h1;
  localparam logic [1:0] SZ_64K = 2'h2;
  localparam logic [1:0] SZ_1M = 2'h3;
  localparam logic [1:0] PR_PRIV_RO = 2'h0;
  localparam logic [1:0] PR_PRIV_RW = 2'h1;
  localparam logic [1:0] PR_USER_RO = 2'h2;
  localparam logic [1:0] PR_USER_RW = 2'h3;

  typedef struct packed {
    logic [VPN_W-1:0] vpn;
    logic [SPACE_IDENTIFIER_W-1:0] space_identifier;
    logic sh;
    logic [1:0] sz;
    logic [1:0] pr;
    logic [PPN_W-1:0] ppn;
  } vat_entry_s;

  localparam int ENTRY_W = $bits(vat_entry_s);

  typedef enum logic [1:0] {
    VAT_IDLE,
    VAT_LOOK,
    VAT_READ,
    VAT_CMP
  } vat_state_e;
endpackage

// >>> src/vat_entry_mem.sv
`timescale 1ns/1ps
module vat_entry_mem #(
  parameter int WIDTH = 54,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clk_in, // Core clock
  input wire logic wr_en_in, // Write strobe
  input wire logic [AW-1:0] wr_addr_in, // Write index
  input wire logic [WIDTH-1:0] wr_data_in, // Write data
  input wire logic [AW-1:0] rd_addr_in, // Read index
  output logic [WIDTH-1:0] rd_data_out // Registered read data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rd_q;

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    rd_q <= mem_q[rd_addr_in];
  end

  assign rd_data_out = rd_q;
endmodule

// >>> src/vat_translator.sv
`timescale 1ns/1ps
// Functional notes
// R1: 32-bit virtual plus 8-bit space to 29-bit
// R2: Four instruction and 64 unified buffer entries
// R3: Hardware copies unified entries into instruction buffer
// R4: Four page sizes: 1K, 4K, 64K, 1M
// R5: Separate privileged and user access rights
// R6: Miss or violation raises exception, no access
// R7: No table walk; software refills entries
// R8: Control register resets to zero
// R9: Registers at fixed control-area addresses, 32-bit
// R10: Registers aliased in area 7 via translation
// R11: Software avoids reserved locations
// R12: Invalidate bit clears all valid bits, reads zero
// R13: Translation disabled means no translation exceptions
module vat_translator (
  input wire logic clk_in, // Core clock
  input wire logic rst_in, // Async reset, high
  input wire logic req_valid_in, // Access request
  output logic req_ready_out, // Ready for request
  input wire logic [vat_pkg::VADDR_W-1:0] req_vaddr_in, // Virtual address
  input wire logic [vat_pkg::SPACE_IDENTIFIER_W-1:0] req_pad_unused_in, // Spare, ignored
  input wire logic req_fetch_in, // Instruction fetch
  input wire logic req_write_in, // Write access
  input wire logic req_priv_in, // Privileged mode
  input wire logic [31:0] req_wdata_in, // Register write data
  input wire logic load_entry_in, // Load entry pulse
  output logic resp_valid_out, // Response pulse
  output logic [vat_pkg::PADDR_W-1:0] resp_paddr_out, // External address
  output logic resp_miss_out, // Miss exception
  output logic resp_prot_out, // Protection exception
  output logic resp_reg_out, // Register access done
  output logic [31:0] resp_rdata_out // Register read data
);
  import vat_pkg::*;

  // ***********************************************************
  // Helper functions
  // ***********************************************************
  function automatic logic [VPN_W-1:0] size_mask(input logic [1:0] sz);
    logic [VPN_W-1:0] m;
    m = '1;
    if (sz == SZ_4K) begin
      m[1:0] = 2'h0;
    end else if (sz == SZ_64K) begin
      m[5:0] = 6'h00;
    end else if (sz == SZ_1M) begin
      m[9:0] = 10'h000;
    end
    return m;
  endfunction

  function automatic logic entry_match(input vat_entry_s e,
                                       input logic [VADDR_W-1:0] va,
                                       input logic [SPACE_IDENTIFIER_W-1:0] space_identifier,
                                       input logic skip_space_identifier);
    logic [VPN_W-1:0] diff;
    diff = (e.vpn ^ va[VADDR_W-1:PEH_VPN_LSB]) & size_mask(e.sz);
    return (diff == '0) && (e.sh || skip_space_identifier || (e.space_identifier == space_identifier));
  endfunction

  function automatic logic [PADDR_W-1:0] entry_paddr(input vat_entry_s e,
      input logic [VADDR_W-1:0] va);
    logic [VPN_W-1:0] full;
    logic [PPN_W-1:0] m;
    logic [PPN_W-1:0] pn;
    full = size_mask(e.sz);
    m = full[PPN_W-1:0];
    pn = (e.ppn & m) | (va[PADDR_W-1:PEL_PPN_LSB] & ~m);
    return {pn, va[PEL_PPN_LSB-1:0]};
  endfunction

  function automatic logic allowed(input logic [1:0] pr, input logic priv,
                                   input logic wr);
    logic ok;
    ok = 1'b0;
    if (priv) begin
      ok = !wr || (pr != PR_PRIV_RO);
    end else begin
      ok = (pr == PR_USER_RW) || ((pr == PR_USER_RO) && !wr);
    end
    return ok;
  endfunction

  // ***********************************************************
  // State
  // ***********************************************************
  vat_state_e state_q, state_d;
  logic [VADDR_W-1:0] vaddr_q, vaddr_d;
  logic fetch_q, fetch_d;
  logic write_q, write_d;
  logic priv_q, priv_d;
  logic [31:0] wdata_q, wdata_d;
  logic [UIDX_W-1:0] scan_q, scan_d;
  logic [31:0] page_entry_high_q, page_entry_high_d;
  logic [31:0] page_entry_low_q, page_entry_low_d;
  logic [31:0] page_entry_assist_q, page_entry_assist_d;
  logic [31:0] ttb_q, ttb_d;
  logic [31:0] tea_q, tea_d;
  logic at_q, at_d;
  logic sv_q, sv_d;
  logic [CNT_W-1:0] urc_q, urc_d;
  logic [CNT_W-1:0] urb_q, urb_d;
  logic [UNIFIED_XLAT_BUFFER_N-1:0] uvalid_q, uvalid_d;
  vat_entry_s instruction_xlat_buffer_q [INSTRUCTION_XLAT_BUFFER_N];
  vat_entry_s instruction_xlat_buffer_d [INSTRUCTION_XLAT_BUFFER_N];
  logic [INSTRUCTION_XLAT_BUFFER_N-1:0] ivalid_q, ivalid_d;
  logic [1:0] irepl_q, irepl_d;
  logic ready_q, ready_d;
  logic rv_q, rv_d;
  logic [PADDR_W-1:0] rpa_q, rpa_d;
  logic rmiss_q, rmiss_d;
  logic rprot_q, rprot_d;
  logic rreg_q, rreg_d;
  logic [31:0] rdata_q, rdata_d;

  vat_entry_s mem_rd;
  vat_entry_s load_ent;
  logic [INSTRUCTION_XLAT_BUFFER_N-1:0] ihit;
  logic skip_space_identifier;

  // ***********************************************************
  // Unified buffer storage
  // ***********************************************************
  assign load_ent.vpn = page_entry_high_q[VADDR_W-1:PEH_VPN_LSB];
  assign load_ent.space_identifier = page_entry_high_q[SPACE_IDENTIFIER_W-1:0];
  assign load_ent.sh = page_entry_low_q[PEL_SH_BIT];
  assign load_ent.sz = {page_entry_low_q[PEL_SZ1_BIT], page_entry_low_q[PEL_SZ0_BIT]};
  assign load_ent.pr = page_entry_low_q[PEL_PR_LSB+1:PEL_PR_LSB];
  assign load_ent.ppn = page_entry_low_q[PADDR_W-1:PEL_PPN_LSB];

  vat_entry_mem #(
    .WIDTH(ENTRY_W),
    .DEPTH(UNIFIED_XLAT_BUFFER_N),
    .AW(UIDX_W)
  ) u_unified_xlat_buffer (
    .clk_in(clk_in),
    .wr_en_in(load_entry_in && ready_q),
    .wr_addr_in(urc_q),
    .wr_data_in(load_ent),
    .rd_addr_in(scan_q),
    .rd_data_out(mem_rd)
  ); // R2 R7

  assign skip_space_identifier = sv_q && priv_q;

  // Parallel compare of the instruction buffer
  for (genvar i = 0; i < INSTRUCTION_XLAT_BUFFER_N; i++) begin : g_ihit
    assign ihit[i] = ivalid_q[i] &&
                     entry_match(instruction_xlat_buffer_q[i], vaddr_q, page_entry_high_q[SPACE_IDENTIFIER_W-1:0],
                                 skip_space_identifier); // R4
  end

  // ***********************************************************
  // Next-state logic
  // ***********************************************************
  always_comb begin
    logic done;
    logic miss;
    logic prot;
    logic is_reg;
    logic [23:0] ofs;
    logic [PADDR_W-1:0] pa;
    vat_entry_s hit_e;
    done = 1'b0;
    miss = 1'b0;
    prot = 1'b0;
    is_reg = 1'b0;
    ofs = 24'h00_0000;
    pa = vaddr_q[PADDR_W-1:0]; // R1
    hit_e = instruction_xlat_buffer_q[0];
    state_d = state_q;
    vaddr_d = vaddr_q;
    fetch_d = fetch_q;
    write_d = write_q;
    priv_d = priv_q;
    wdata_d = wdata_q;
    scan_d = scan_q;
    page_entry_high_d = page_entry_high_q;
    page_entry_low_d = page_entry_low_q;
    page_entry_assist_d = page_entry_assist_q;
    ttb_d = ttb_q;
    tea_d = tea_q;
    at_d = at_q;
    sv_d = sv_q;
    urc_d = urc_q;
    urb_d = urb_q;
    uvalid_d = uvalid_q;
    instruction_xlat_buffer_d = instruction_xlat_buffer_q;
    ivalid_d = ivalid_q;
    irepl_d = irepl_q;
    rv_d = 1'b0;
    rpa_d = rpa_q;
    rmiss_d = rmiss_q;
    rprot_d = rprot_q;
    rreg_d = rreg_q;
    rdata_d = rdata_q;

    if (load_entry_in && ready_q) begin
      uvalid_d[urc_q] = page_entry_low_q[PEL_V_BIT]; // R7
    end

    case (state_q)
      VAT_IDLE: begin
        if (req_valid_in && ready_q) begin
          vaddr_d = req_vaddr_in;
          fetch_d = req_fetch_in;
          write_d = req_write_in;
          priv_d = req_priv_in;
          wdata_d = req_wdata_in;
          state_d = VAT_LOOK;
        end
      end
      VAT_LOOK: begin
        if (vaddr_q[VADDR_W-1:24] == CTRL_AREA_TOP) begin
          done = 1'b1;
          prot = !priv_q;
          is_reg = priv_q; // R9
          ofs = vaddr_q[23:0];
        end else if (!at_q) begin
          done = 1'b1; // R13
          prot = !priv_q && vaddr_q[VADDR_W-1];
        end else if (vaddr_q[VADDR_W-1] &&
                     (vaddr_q[VADDR_W-1:PADDR_W] != 3'h6)) begin
          done = 1'b1;
          prot = !priv_q;
        end else if (fetch_q && (ihit != '0)) begin
          for (int i = INSTRUCTION_XLAT_BUFFER_N - 1; i >= 0; i--) begin
            if (ihit[i]) begin
              hit_e = instruction_xlat_buffer_q[i];
            end
          end
          done = 1'b1;
          prot = !allowed(hit_e.pr, priv_q, 1'b0); // R5
          pa = entry_paddr(hit_e, vaddr_q); // R4
        end else begin
          scan_d = '0;
          state_d = VAT_READ;
        end
      end
      VAT_READ: begin
        state_d = VAT_CMP;
      end
      VAT_CMP: begin
        if (uvalid_q[scan_q] &&
            entry_match(mem_rd, vaddr_q, page_entry_high_q[SPACE_IDENTIFIER_W-1:0], skip_space_identifier)) begin
          done = 1'b1;
          prot = !allowed(mem_rd.pr, priv_q, write_q && !fetch_q); // R5
          pa = entry_paddr(mem_rd, vaddr_q); // R4
          if (fetch_q) begin
            instruction_xlat_buffer_d[irepl_q] = mem_rd; // R3
            ivalid_d[irepl_q] = 1'b1; // R3
            irepl_d = irepl_q + 2'h1;
          end
          if (urb_q != '0 && urc_q == urb_q) begin
            urc_d = '0;
          end else begin
            urc_d = urc_q + 6'h01;
          end
        end else if (scan_q == UIDX_W'(UNIFIED_XLAT_BUFFER_N - 1)) begin
          done = 1'b1;
          miss = 1'b1; // R6
        end else begin
          scan_d = scan_q + 6'h01;
          state_d = VAT_READ;
        end
        if (done && !prot && !miss &&
            pa[PADDR_W-1:24] == AREA7_TOP) begin
          is_reg = 1'b1; // R10
          ofs = pa[23:0];
        end
      end
      default: begin
        state_d = VAT_IDLE;
      end
    endcase

    if (state_q == VAT_LOOK && done && !prot && fetch_q && ihit != '0 &&
        pa[PADDR_W-1:24] == AREA7_TOP) begin
      is_reg = 1'b1; // R10
      ofs = pa[23:0];
    end

    if (done) begin
      state_d = VAT_IDLE;
      rv_d = 1'b1;
      rpa_d = pa;
      rmiss_d = miss;
      rprot_d = prot;
      rreg_d = is_reg;
      rdata_d = 32'h0000_0000;
      if (miss || prot) begin
        tea_d = vaddr_q; // R6
        page_entry_high_d[VADDR_W-1:PEH_VPN_LSB] = vaddr_q[VADDR_W-1:PEH_VPN_LSB];
      end
    end

    // Register decode, unmapped reads zero and writes drop
    if (is_reg) begin
      if (ofs == REG_PAGE_ENTRY_HIGH[23:0]) begin
        rdata_d = page_entry_high_q;
        if (write_q) page_entry_high_d = wdata_q;
      end else if (ofs == REG_PAGE_ENTRY_LOW[23:0]) begin
        rdata_d = page_entry_low_q;
        if (write_q) page_entry_low_d = wdata_q;
      end else if (ofs == REG_TABLE_BASE[23:0]) begin
        rdata_d = ttb_q;
        if (write_q) ttb_d = wdata_q;
      end else if (ofs == REG_FAULT_ADDRESS[23:0]) begin
        rdata_d = tea_q;
        if (write_q) tea_d = wdata_q;
      end else if (ofs == REG_PAGE_ENTRY_ASSIST[23:0]) begin
        rdata_d = page_entry_assist_q;
        if (write_q) page_entry_assist_d = wdata_q;
      end else if (ofs == REG_TRANSLATOR_CONTROL[23:0]) begin
        rdata_d[CTRL_AT_BIT] = at_q;
        rdata_d[CTRL_SV_BIT] = sv_q;
        rdata_d[CTRL_URC_LSB+CNT_W-1:CTRL_URC_LSB] = urc_q;
        rdata_d[CTRL_URB_LSB+CNT_W-1:CTRL_URB_LSB] = urb_q; // R12
        if (write_q) begin
          at_d = wdata_q[CTRL_AT_BIT];
          sv_d = wdata_q[CTRL_SV_BIT];
          urc_d = wdata_q[CTRL_URC_LSB+CNT_W-1:CTRL_URC_LSB];
          urb_d = wdata_q[CTRL_URB_LSB+CNT_W-1:CTRL_URB_LSB];
          if (wdata_q[CTRL_TI_BIT]) begin
            uvalid_d = '0; // R12
            ivalid_d = '0; // R12
          end
        end
      end
    end

    ready_d = (state_d == VAT_IDLE);
  end

  // ***********************************************************
  // Registers
  // ***********************************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= VAT_IDLE;
      vaddr_q <= REG_RESET;
      fetch_q <= 1'b0;
      write_q <= 1'b0;
      priv_q <= 1'b0;
      wdata_q <= REG_RESET;
      scan_q <= '0;
      page_entry_high_q <= REG_RESET;
      page_entry_low_q <= REG_RESET;
      page_entry_assist_q <= REG_RESET;
      ttb_q <= REG_RESET;
      tea_q <= REG_RESET;
      at_q <= CTRL_RESET[CTRL_AT_BIT]; // R8
      sv_q <= CTRL_RESET[CTRL_SV_BIT]; // R8
      urc_q <= CTRL_RESET[CTRL_URC_LSB+CNT_W-1:CTRL_URC_LSB]; // R8
      urb_q <= CTRL_RESET[CTRL_URB_LSB+CNT_W-1:CTRL_URB_LSB]; // R8
      uvalid_q <= '0;
      for (int i = 0; i < INSTRUCTION_XLAT_BUFFER_N; i++) begin
        instruction_xlat_buffer_q[i] <= '0;
      end
      ivalid_q <= '0;
      irepl_q <= 2'h0;
      ready_q <= 1'b1;
      rv_q <= 1'b0;
      rpa_q <= '0;
      rmiss_q <= 1'b0;
      rprot_q <= 1'b0;
      rreg_q <= 1'b0;
      rdata_q <= REG_RESET;
    end else begin
      state_q <= state_d;
      vaddr_q <= vaddr_d;
      fetch_q <= fetch_d;
      write_q <= write_d;
      priv_q <= priv_d;
      wdata_q <= wdata_d;
      scan_q <= scan_d;
      page_entry_high_q <= page_entry_high_d;
      page_entry_low_q <= page_entry_low_d;
      page_entry_assist_q <= page_entry_assist_d;
      ttb_q <= ttb_d;
      tea_q <= tea_d;
      at_q <= at_d;
      sv_q <= sv_d;
      urc_q <= urc_d;
      urb_q <= urb_d;
      uvalid_q <= uvalid_d;
      instruction_xlat_buffer_q <= instruction_xlat_buffer_d;
      ivalid_q <= ivalid_d;
      irepl_q <= irepl_d;
      ready_q <= ready_d;
      rv_q <= rv_d;
      rpa_q <= rpa_d;
      rmiss_q <= rmiss_d;
      rprot_q <= rprot_d;
      rreg_q <= rreg_d;
      rdata_q <= rdata_d;
    end
  end

  assign req_ready_out = ready_q;
  assign resp_valid_out = rv_q;
  assign resp_paddr_out = rpa_q;
  assign resp_miss_out = rmiss_q;
  assign resp_prot_out = rprot_q;
  assign resp_reg_out = rreg_q;
  assign resp_rdata_out = rdata_q;
endmodule

// >>> verif/vat_translator_checker.sv
`timescale 1ns/1ps
module vat_translator_checker (
  input wire logic clk_in, // Core clock
  input wire logic rst_in, // Async reset
  input wire logic req_valid_in, // Request
  input wire logic req_ready_out, // Ready
  input wire logic [vat_pkg::VADDR_W-1:0] req_vaddr_in, // Address
  input wire logic req_write_in, // Write
  input wire logic req_priv_in, // Privileged
  input wire logic [31:0] req_wdata_in, // Write data
  input wire logic resp_valid_out, // Response
  input wire logic [vat_pkg::PADDR_W-1:0] resp_paddr_out, // Address out
  input wire logic resp_miss_out, // Miss
  input wire logic resp_prot_out, // Violation
  input wire logic resp_reg_out, // Register access
  input wire logic [31:0] resp_rdata_out // Read data
);
  import vat_pkg::*;
  logic take;
  logic at_q;
  logic wr_q;
  logic [31:0] va_q;
  assign take = req_valid_in && req_ready_out;
  // Shadow of last request and of translation enable
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      at_q <= 1'b0;
      wr_q <= 1'b0;
      va_q <= 32'h0000_0000;
    end else if (take) begin
      wr_q <= req_write_in;
      va_q <= req_vaddr_in;
      if (req_write_in && req_priv_in &&
          req_vaddr_in == REG_TRANSLATOR_CONTROL) begin
        at_q <= req_wdata_in[CTRL_AT_BIT];
      end
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_ready_low: assert property (take |=> !req_ready_out)
    else $error("ready high right after a taken request");
  a_resp_pulse: assert property (
    resp_valid_out |-> req_ready_out ##1 !resp_valid_out)
    else $error("response not a single cycle with ready");
  a_resp_bound: assert property (
    take |=> !resp_valid_out ##[1:129] resp_valid_out)
    else $error("response outside its time bound");
  a_reg_time: assert property (
    take && req_priv_in && req_vaddr_in[31:24] == CTRL_AREA_TOP |->
    ##2 resp_valid_out && !resp_prot_out && !resp_miss_out)
    else $error("control area access not answered in two cycles");
  a_user_ctrl: assert property (
    take && !req_priv_in && req_vaddr_in[31:24] == CTRL_AREA_TOP |->
    ##2 resp_valid_out && resp_prot_out && !resp_reg_out)
    else $error("user control area access not refused");
  a_no_miss_off: assert property (
    resp_valid_out && !at_q |-> !resp_miss_out)
    else $error("miss raised with translation off");
  a_off_identity: assert property (
    resp_valid_out && !at_q && !resp_reg_out && !resp_prot_out |->
    resp_paddr_out == va_q[28:0])
    else $error("untranslated address wrong");
  a_ctrl_readback: assert property (
    resp_valid_out && resp_reg_out && !wr_q &&
    va_q == REG_TRANSLATOR_CONTROL |->
    resp_rdata_out[CTRL_AT_BIT] == at_q && !resp_rdata_out[CTRL_TI_BIT])
    else $error("control readback wrong");
endmodule
bind vat_translator vat_translator_checker vat_translator_checker_i (
  .clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
  .req_ready_out(req_ready_out), .req_vaddr_in(req_vaddr_in),
  .req_write_in(req_write_in), .req_priv_in(req_priv_in),
  .req_wdata_in(req_wdata_in), .resp_valid_out(resp_valid_out),
  .resp_paddr_out(resp_paddr_out), .resp_miss_out(resp_miss_out),
  .resp_prot_out(resp_prot_out), .resp_reg_out(resp_reg_out),
  .resp_rdata_out(resp_rdata_out)
);

// >>> verif/vat_core_model.sv
`timescale 1ns/1ps
module vat_core_model (
  input wire logic clk_in, // Core clock
  input wire logic resp_valid_in, // Response pulse
  output logic req_valid_out, // Request
  output logic [31:0] req_vaddr_out, // Virtual address
  output logic req_fetch_out, // Fetch
  output logic req_write_out, // Write
  output logic req_priv_out, // Privileged
  output logic [31:0] req_wdata_out, // Write data
  output logic load_entry_out // Load pulse
);
  initial begin
    req_valid_out = 1'b0;
    req_vaddr_out = 32'h0000_0000;
    req_fetch_out = 1'b0;
    req_write_out = 1'b0;
    req_priv_out = 1'b1;
    req_wdata_out = 32'h0000_0000;
    load_entry_out = 1'b0;
  end
  // Word access, off-map only when told; latency or -1
  task automatic access(input logic [31:0] va, input logic f, w, p,
      input logic [31:0] wd, output int lat);
    lat = -1;
    @(posedge clk_in);
    #1;
    req_valid_out = 1'b1;
    req_vaddr_out = va;
    req_fetch_out = f;
    req_write_out = w;
    req_priv_out = p;
    req_wdata_out = wd;
    @(posedge clk_in);
    #1;
    req_valid_out = 1'b0;
    req_vaddr_out = ~va;
    req_wdata_out = ~wd;
    for (int n = 1; n <= 200; n++) begin
      if (resp_valid_in) begin
        lat = n;
        break;
      end
      @(posedge clk_in);
      #1;
    end
  endtask
  task automatic load_entry();
    @(posedge clk_in);
    #1;
    load_entry_out = 1'b1;
    @(posedge clk_in);
    #1;
    load_entry_out = 1'b0;
  endtask
endmodule

// >>> verif/vat_translator_test.sv
`timescale 1ns/1ps
module vat_translator_test;
  import vat_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_valid, req_ready, req_fetch, req_write, req_priv, load_entry;
  logic resp_valid, resp_miss, resp_prot, resp_reg;
  logic [31:0] req_vaddr, req_wdata, resp_rdata;
  logic [PADDR_W-1:0] resp_paddr;
  int err_count = 0;
  int num_checks = 0;
  int lat;
  always #2.5 clk_in = ~clk_in;
  vat_translator vat_translator_i (.clk_in(clk_in), .rst_in(rst_in),
    .req_valid_in(req_valid), .req_ready_out(req_ready),
    .req_vaddr_in(req_vaddr), .req_pad_unused_in(8'h00),
    .req_fetch_in(req_fetch), .req_write_in(req_write),
    .req_priv_in(req_priv), .req_wdata_in(req_wdata),
    .load_entry_in(load_entry), .resp_valid_out(resp_valid),
    .resp_paddr_out(resp_paddr), .resp_miss_out(resp_miss),
    .resp_prot_out(resp_prot), .resp_reg_out(resp_reg),
    .resp_rdata_out(resp_rdata));
  vat_core_model vat_core_model_i (.clk_in(clk_in),
    .resp_valid_in(resp_valid), .req_valid_out(req_valid),
    .req_vaddr_out(req_vaddr), .req_fetch_out(req_fetch),
    .req_write_out(req_write), .req_priv_out(req_priv),
    .req_wdata_out(req_wdata), .load_entry_out(load_entry));
  task automatic end_of_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [31:0] va, input logic f, w, p,
      input logic [31:0] wd);
    vat_core_model_i.access(va, f, w, p, wd, lat);
    if (lat < 0) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    acc(a, 1'b0, 1'b1, 1'b1, d);
  endtask
  task automatic rd(input logic [31:0] a);
    acc(a, 1'b0, 1'b0, 1'b1, 32'h0000_0000);
  endtask
  task automatic flags(input logic [2:0] e);
    check({29'h0, resp_miss, resp_prot, resp_reg}, {29'h0, e});
  endtask
  task automatic chk_lat(input int n);
    check(32'(lat), 32'(n));
  endtask
  task automatic ld(input int idx, input logic [31:0] va, pa,
      input logic [1:0] sz, pr);
    wr(REG_TRANSLATOR_CONTROL, 32'h0000_0001 | (32'(idx) << CTRL_URC_LSB));
    wr(REG_PAGE_ENTRY_HIGH, {va[31:10], 2'h0, 8'h5a});
    wr(REG_PAGE_ENTRY_LOW, {3'h0, pa[28:10], 2'h1, sz[1], pr, sz[0], 4'h0});
    vat_core_model_i.load_entry();
  endtask
  task automatic t_regs();
    logic [31:0] regs [5];
    regs = '{REG_PAGE_ENTRY_HIGH, REG_PAGE_ENTRY_LOW, REG_TABLE_BASE,
             REG_FAULT_ADDRESS, REG_PAGE_ENTRY_ASSIST};
    rd(REG_TRANSLATOR_CONTROL);
    check(resp_rdata, CTRL_RESET);
    chk_lat(2);
    for (int i = 0; i < 5; i++) wr(regs[i], 32'hc3a5_0f00 + 32'(i));
    for (int i = 0; i < 5; i++) begin
      rd(regs[i]);
      check(resp_rdata, 32'hc3a5_0f00 + 32'(i));
    end
    wr(32'hff00_0020, 32'hffff_ffff);
    rd(32'hff00_0020);
    check(resp_rdata, 32'h0000_0000);
    wr(REG_TRANSLATOR_CONTROL, 32'h0000_0004);
    rd(REG_TRANSLATOR_CONTROL);
    check(resp_rdata, 32'h0000_0000);
  endtask
  task automatic t_off();
    acc(REG_PAGE_ENTRY_HIGH, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
    flags(3'h2);
    acc(32'h6abc_def0, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
    check({3'h0, resp_paddr}, 32'h0abc_def0);
    flags(3'h0);
    acc(32'h8000_0000, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
    flags(3'h2);
  endtask
  task automatic t_sizes();
    logic [31:0] msk [4];
    logic [31:0] off;
    msk = '{32'h0000_03ff, 32'h0000_0fff, 32'h0000_ffff, 32'h000f_ffff};
    for (int k = 0; k < 4; k++) begin
      ld(k, 32'h0010_0000 * (k + 1), 32'h0100_0000 * (k + 1), 2'(k),
         PR_USER_RW);
    end
    for (int k = 0; k < 4; k++) begin
      off = 32'h0005_5554 & msk[k];
      acc(32'h0010_0000 * (k + 1) | off, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
      check({3'h0, resp_paddr}, 32'h0100_0000 * (k + 1) | off);
      flags(3'h0);
      chk_lat(4 + 2 * k);
    end
    ld(63, 32'h0080_0000, 32'h0050_0000, SZ_1K, PR_USER_RW);
    acc(32'h0080_0104, 1'b0, 1'b0, 1'b1, 32'h0000_0000);
    check({3'h0, resp_paddr}, 32'h0050_0104);
    chk_lat(130);
    rd(32'h0900_0400);
    flags(3'h4);
    chk_lat(130);
    rd(REG_FAULT_ADDRESS);
    check(resp_rdata, 32'h0900_0400);
    rd(REG_PAGE_ENTRY_HIGH);
    check(resp_rdata & 32'hffff_fc00, 32'h0900_0400);
    rd(32'h0900_0400);
    flags(3'h4);
    wr(REG_PAGE_ENTRY_HIGH, 32'h0000_0033);
    rd(32'h0010_0154);
    flags(3'h4);
    wr(REG_TRANSLATOR_CONTROL, 32'h0000_0101);
    rd(32'h0010_0154);
    flags(3'h0);
    check({3'h0, resp_paddr}, 32'h0100_0154);
    acc(32'h0010_0154, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
    flags(3'h4);
  endtask
  task automatic t_rights();
    logic [3:0] ok [4];
    ok = '{4'h8, 4'hc, 4'he, 4'hf};
    for (int r = 0; r < 4; r++) begin
      ld(0, 32'h0200_0000, 32'h0300_0000, SZ_4K, 2'(r));
      for (int m = 0; m < 4; m++) begin
        acc(32'h0200_0010, 1'b0, m[0], m < 2, 32'h0000_0000);
        flags({1'b0, !ok[r][3-m], 1'b0});
      end
    end
  endtask
  task automatic t_fetch();
    wr(REG_TRANSLATOR_CONTROL, 32'h0000_0005);
    ld(0, 32'h0300_0000, 32'h0400_0000, SZ_4K, PR_USER_RW);
    acc(32'h0300_0020, 1'b1, 1'b0, 1'b1, 32'h0000_0000);
    chk_lat(4);
    acc(32'h0300_0020, 1'b1, 1'b0, 1'b1, 32'h0000_0000);
    chk_lat(2);
    check({3'h0, resp_paddr}, 32'h0400_0020);
    wr(REG_TRANSLATOR_CONTROL, 32'h0000_0005);
    acc(32'h0300_0020, 1'b1, 1'b0, 1'b1, 32'h0000_0000);
    flags(3'h4);
    wr(REG_TABLE_BASE, 32'h0bad_cafe);
    ld(1, 32'h0500_0000, 32'h1f00_0000, SZ_1M, PR_PRIV_RW);
    rd(32'h0500_0008);
    flags(3'h1);
    check(resp_rdata, 32'h0bad_cafe);
    wr(32'h0500_0008, 32'h1357_9bdf);
    rd(REG_TABLE_BASE);
    check(resp_rdata, 32'h1357_9bdf);
    wr(REG_TRANSLATOR_CONTROL, 32'h0000_0000);
    rd(32'h0900_0400);
    flags(3'h0);
  endtask
  task automatic t_reset();
    wr(REG_TRANSLATOR_CONTROL, 32'h0000_0101);
    @(posedge clk_in);
    #1;
    rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    rd(REG_TRANSLATOR_CONTROL);
    check(resp_rdata, CTRL_RESET);
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    t_regs();
    t_off();
    t_sizes();
    t_rights();
    t_fetch();
    t_reset();
    end_of_test();
  end
endmodule
